// ==== rtl/lsd_pkg.sv ====
// Shared constants, types and helpers for the LED sink driver control
package lsd_pkg;

    // ********************************************************************
    // Widths and reset values
    // ********************************************************************
    localparam int CH_NUM = 8;
    typedef logic [CH_NUM-1:0] lsd_word_t;
    localparam lsd_word_t WORD_RST = 8'h00;
    localparam logic OE_IDLE = 1'h1;
    localparam logic [1:0] HIST_RST = 2'h0;

    // ********************************************************************
    // Operating modes and mode-switch phases
    // ********************************************************************
    typedef enum logic [0:0] {
        LSD_MODE_NORMAL = 1'b0,
        LSD_MODE_DETECT = 1'b1
    } lsd_mode_t;

    typedef enum logic [1:0] {
        LSD_SW_IDLE = 2'b00,
        LSD_SW_SAMPLE = 2'b01,
        LSD_SW_TAIL = 2'b10
    } lsd_sw_t;

    // ********************************************************************
    // Low-sample counting during detection
    // ********************************************************************
    localparam logic [1:0] LOW_CNT_RST = 2'h0;
    localparam logic [1:0] LOW_CNT_LOAD = 2'h2;
    localparam logic [1:0] LOW_CNT_MAX = 2'h3;

    // ********************************************************************
    // Status settle time on the system clock
    // ********************************************************************
    localparam int SETTLE_TIME_NS = 2000;
    localparam int CLK_PERIOD_NS = 40;
    localparam int SETTLE_CYCLES = (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SETTLE_W = 6;
    localparam logic [SETTLE_W-1:0] SETTLE_RST = 6'h00;
    localparam logic [SETTLE_W-1:0] SETTLE_LAST = SETTLE_W'(SETTLE_CYCLES - 1);

    // Status bit: channel sinking and its current at or above threshold
    function automatic lsd_word_t status_code(lsd_word_t latched, lsd_word_t level_ok, logic enabled);
        return latched & level_ok & {CH_NUM{enabled}};
    endfunction

endpackage

// ==== rtl/lsd_mode_if.sv ====
// Signals between the serial datapath and the mode-switch detector
`timescale 1ns/1ps
`default_nettype none
interface lsd_mode_if;
    logic oe_lvl;
    logic le_lvl;
    logic detect_mode;
    logic latch_block;

    modport ctrl (input oe_lvl, input le_lvl, output detect_mode, output latch_block);
    modport user (output oe_lvl, output le_lvl, input detect_mode, input latch_block);
endinterface
`default_nettype wire

// ==== rtl/lsd_sync3.sv ====
// Three-flop input synchroniser that accepts a change once stages agree
`timescale 1ns/1ps
`default_nettype none
module lsd_sync3 #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);

    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    logic [W-1:0] out_q;
    logic agree;

    // Stage one feeds only stage two; filtering looks at two and three
    assign agree = (s2_q == s3_q);

    // ********************************************************************
    // Synchroniser chain
    // ********************************************************************
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            s1_q <= RST_VAL;
            s2_q <= RST_VAL;
            s3_q <= RST_VAL;
            out_q <= RST_VAL;
        end else begin
            s1_q <= async_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (agree) begin
                out_q <= s3_q;
            end
        end
    end

    assign sync_out = out_q;

endmodule
`default_nettype wire

// ==== rtl/lsd_mode_switch.sv ====
// Short-pulse detector that moves between normal and detection modes
`timescale 1ns/1ps
`default_nettype none
module lsd_mode_switch (
    input wire logic sclk_in,
    input wire logic arst_n_in,
    lsd_mode_if.ctrl mif
);

    logic [1:0] oe_hist_q;
    lsd_pkg::lsd_sw_t sw_q;
    lsd_pkg::lsd_sw_t sw_d;
    lsd_pkg::lsd_mode_t mode_q;
    lsd_pkg::lsd_mode_t mode_d;
    logic pulse_start;

    // High, low, high on three edges; a new pulse waits for the phase to end
    assign pulse_start = mif.oe_lvl & ~oe_hist_q[0] & oe_hist_q[1] & (sw_q == lsd_pkg::LSD_SW_IDLE); // RULE2

    // ********************************************************************
    // Phase sequencing
    // ********************************************************************
    always_comb begin
        sw_d = sw_q;
        mode_d = mode_q;
        unique case (sw_q)
            lsd_pkg::LSD_SW_IDLE: begin
                if (pulse_start) begin
                    sw_d = lsd_pkg::LSD_SW_SAMPLE; // RULE2
                end
            end
            lsd_pkg::LSD_SW_SAMPLE: begin
                // Fourth edge picks the mode from the latch line
                mode_d = mif.le_lvl ? lsd_pkg::LSD_MODE_DETECT : lsd_pkg::LSD_MODE_NORMAL; // RULE3
                sw_d = lsd_pkg::LSD_SW_TAIL;
            end
            lsd_pkg::LSD_SW_TAIL: begin
                sw_d = lsd_pkg::LSD_SW_IDLE;
            end
            default: begin
                sw_d = lsd_pkg::LSD_SW_IDLE;
            end
        endcase
    end

    // Power-up lands in normal mode
    always_ff @(posedge sclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            oe_hist_q <= lsd_pkg::HIST_RST;
            sw_q <= lsd_pkg::LSD_SW_IDLE;
            mode_q <= lsd_pkg::LSD_MODE_NORMAL; // RULE1
        end else begin
            oe_hist_q <= {oe_hist_q[0], mif.oe_lvl};
            sw_q <= sw_d;
            mode_q <= mode_d;
        end
    end

    // Edges three to five steer the mode only, never the latch
    assign mif.latch_block = pulse_start | (sw_q != lsd_pkg::LSD_SW_IDLE); // RULE4
    assign mif.detect_mode = (mode_q == lsd_pkg::LSD_MODE_DETECT);

    // ********************************************************************
    // Checks
    // ********************************************************************
    sequence s_short_pulse;
        mif.oe_lvl ##1 !mif.oe_lvl ##1 (mif.oe_lvl && sw_q == lsd_pkg::LSD_SW_IDLE);
    endsequence

    sequence s_phase_walk;
        (sw_q == lsd_pkg::LSD_SW_SAMPLE) ##1 (sw_q == lsd_pkg::LSD_SW_TAIL) ##1 (sw_q == lsd_pkg::LSD_SW_IDLE);
    endsequence

    a_switch_phase_len: assert property (@(posedge sclk_in) disable iff (!arst_n_in) // RULE2
        s_short_pulse |=> s_phase_walk)
        else $error("mode switch phase length wrong");

    a_mode_from_latch: assert property (@(posedge sclk_in) disable iff (!arst_n_in) // RULE3
        s_short_pulse |=> ##1 (mif.detect_mode == $past(mif.le_lvl)))
        else $error("mode not taken from latch line at fourth edge");

    a_latch_blocked: assert property (@(posedge sclk_in) disable iff (!arst_n_in) // RULE4
        s_short_pulse |-> mif.latch_block [*3])
        else $error("latch not blocked during mode switch");

    a_mode_steady: assert property (@(posedge sclk_in) disable iff (!arst_n_in) // RULE1
        (sw_q != lsd_pkg::LSD_SW_SAMPLE) |=> $stable(mode_q))
        else $error("mode changed outside the sampling edge");

endmodule
`default_nettype wire

// ==== rtl/lsd_top.sv ====
// LED sink driver control: serial path, output latch, mode switch, detection
//
// Functional notes
// RULE1 - Power-up starts in normal mode
// RULE2 - Short high-low-high pulse opens two-clock switch phase
// RULE3 - Fourth edge latch level chooses detection or normal
// RULE4 - Edges three to five never latch data
// RULE5 - Switch pulse low still enables sinks
// RULE6 - Shifting continues during mode switch
// RULE7 - Serial bits shift in, oldest bit out
// RULE8 - Latch line copies shift register outside switching
// RULE9 - Enable line gates latched channel sinks
// RULE10 - Controller keeps sinks enabled while detecting
// RULE11 - Open check: on and above threshold gives 1
// RULE12 - Healthy open check equals latch contents
// RULE13 - Short check: on and above threshold means shorted
// RULE14 - Fault-free status word matches latch bitwise
// RULE15 - After second low, source becomes status word
// RULE16 - Third and later lows load status word
// RULE17 - Enable high: serial source back, sinks off
// RULE18 - Controller holds enable low two microseconds
// RULE19 - Eight-bit shift register, one step per edge
// RULE20 - Output enable is active low
// RULE21 - Latch transparent while latch line high
`timescale 1ns/1ps
`default_nettype none
module lsd_top (
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire logic sclk_in,
    input wire logic serial_in_in,
    input wire logic latch_mode_select_in,
    input wire logic output_enable_switch_detect_in,
    input wire logic [lsd_pkg::CH_NUM-1:0] current_ok_in,
    output logic serial_out_out,
    output logic [lsd_pkg::CH_NUM-1:0] channel_sink_out,
    output logic detect_mode_out,
    output logic status_capture_out,
    output logic status_settled_out
);

    // ********************************************************************
    // Declarations
    // ********************************************************************
    lsd_mode_if mif ();

    lsd_pkg::lsd_word_t shreg_q;
    lsd_pkg::lsd_word_t shreg_d;
    lsd_pkg::lsd_word_t latch_q;
    lsd_pkg::lsd_word_t latch_d;
    lsd_pkg::lsd_word_t sink_q;
    lsd_pkg::lsd_word_t sink_d;
    lsd_pkg::lsd_word_t level_ok;
    lsd_pkg::lsd_word_t status_word;
    logic [1:0] low_cnt_q;
    logic [1:0] low_cnt_d;
    logic oe_low;
    logic latch_load;
    logic status_src;
    logic load_status;
    logic first_load;
    logic cap_tgl_q;

    logic tgl_s1_q;
    logic tgl_s2_q;
    logic tgl_s3_q;
    logic cap_pulse_q;
    logic oe_clk;
    logic [lsd_pkg::SETTLE_W-1:0] settle_cnt_q;
    logic [lsd_pkg::SETTLE_W-1:0] settle_cnt_d;
    logic settled_q;
    logic settle_done;

    // ********************************************************************
    // Link domain: serial clock
    // ********************************************************************

    // Controller pins are launched on the serial clock, so no sync needed
    assign mif.oe_lvl = output_enable_switch_detect_in;
    assign mif.le_lvl = latch_mode_select_in;

    lsd_mode_switch u_mode (
        .sclk_in(sclk_in),
        .arst_n_in(arst_n_in),
        .mif(mif)
    );

    // Comparator outputs are analog-timed, hence the filtered chain
    lsd_sync3 #(
        .W(lsd_pkg::CH_NUM),
        .RST_VAL(lsd_pkg::WORD_RST)
    ) u_level_sync (
        .clk_in(sclk_in),
        .arst_n_in(arst_n_in),
        .async_in(current_ok_in),
        .sync_out(level_ok)
    );

    // Enable is active low; the switch pulse low also enables
    assign oe_low = ~mif.oe_lvl; // RULE20 RULE5

    // Latch follows the shift register while the line is high, except during a mode switch
    assign latch_load = mif.le_lvl & ~mif.latch_block; // RULE8 RULE21
    assign latch_d = latch_load ? shreg_q : latch_q;

    // Sinks follow latched bits only while enabled
    assign sink_d = latch_d & {lsd_pkg::CH_NUM{oe_low}}; // RULE9

    // Count consecutive low samples, saturating
    assign low_cnt_d = mif.oe_lvl ? lsd_pkg::LOW_CNT_RST :
                       (low_cnt_q == lsd_pkg::LOW_CNT_MAX) ? lsd_pkg::LOW_CNT_MAX : low_cnt_q + 2'h1;

    // After the second low the parallel status word feeds the register
    assign status_src = mif.detect_mode & (low_cnt_q >= lsd_pkg::LOW_CNT_LOAD); // RULE15
    assign load_status = status_src & oe_low; // RULE16
    assign first_load = load_status & (low_cnt_q == lsd_pkg::LOW_CNT_LOAD);

    // Same code serves open and short checks; only biasing differs
    assign status_word = lsd_pkg::status_code(sink_q, level_ok, oe_low); // RULE11 RULE13 RULE12 RULE14

    // Returning high switches back to serial input; shift otherwise
    assign shreg_d = load_status ? status_word : {shreg_q[lsd_pkg::CH_NUM-2:0], serial_in_in}; // RULE7 RULE17 RULE6

    // Datapath registers
    always_ff @(posedge sclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            shreg_q <= lsd_pkg::WORD_RST;
            latch_q <= lsd_pkg::WORD_RST;
            sink_q <= lsd_pkg::WORD_RST;
            low_cnt_q <= lsd_pkg::LOW_CNT_RST;
        end else begin
            shreg_q <= shreg_d; // RULE19
            latch_q <= latch_d;
            sink_q <= sink_d; // RULE17
            low_cnt_q <= low_cnt_d;
        end
    end

    // One toggle per detection window, taken across as an event
    always_ff @(posedge sclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            cap_tgl_q <= 1'b0;
        end else if (first_load) begin
            cap_tgl_q <= ~cap_tgl_q;
        end
    end

    // Oldest bit leaves for the next device in the chain
    assign serial_out_out = shreg_q[lsd_pkg::CH_NUM-1]; // RULE7
    assign channel_sink_out = sink_q;

    // ********************************************************************
    // System domain: status reporting
    // ********************************************************************

    // Enable pin seen on the system clock, filtered
    lsd_sync3 #(
        .W(1),
        .RST_VAL(lsd_pkg::OE_IDLE)
    ) u_oe_sync (
        .clk_in(clk_in),
        .arst_n_in(arst_n_in),
        .async_in(output_enable_switch_detect_in),
        .sync_out(oe_clk)
    );

    // Mode level crosses through the same filtered chain; it only moves
    // once per switch phase, so a slow level crossing is safe here
    lsd_sync3 #(
        .W(1),
        .RST_VAL(lsd_pkg::LSD_MODE_NORMAL)
    ) u_mode_sync (
        .clk_in(clk_in),
        .arst_n_in(arst_n_in),
        .async_in(mif.detect_mode),
        .sync_out(detect_mode_out)
    );

    // Count low time so software knows when status has settled
    assign settle_done = (settle_cnt_q == lsd_pkg::SETTLE_LAST);
    assign settle_cnt_d = oe_clk ? lsd_pkg::SETTLE_RST :
                          settle_done ? settle_cnt_q : settle_cnt_q + 6'h01; // RULE18

    // Capture event and settle timer
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            tgl_s1_q <= 1'b0;
            tgl_s2_q <= 1'b0;
            tgl_s3_q <= 1'b0;
            cap_pulse_q <= 1'b0;
            settle_cnt_q <= lsd_pkg::SETTLE_RST;
            settled_q <= 1'b0;
        end else begin
            tgl_s1_q <= cap_tgl_q;
            tgl_s2_q <= tgl_s1_q;
            tgl_s3_q <= tgl_s2_q;
            cap_pulse_q <= tgl_s2_q ^ tgl_s3_q;
            settle_cnt_q <= settle_cnt_d;
            settled_q <= settle_done & ~oe_clk;
        end
    end

    assign status_capture_out = cap_pulse_q;
    assign status_settled_out = settled_q;

    // ********************************************************************
    // Checks
    // ********************************************************************
    a_shift_serial: assert property (@(posedge sclk_in) disable iff (!arst_n_in) // RULE7
        !load_status |=> shreg_q == {$past(shreg_q[lsd_pkg::CH_NUM-2:0]), $past(serial_in_in)})
        else $error("serial shift lost a bit");

    a_cascade_out: assert property (@(posedge sclk_in) disable iff (!arst_n_in) // RULE19
        (!load_status) [*8] |=> serial_out_out == $past(serial_in_in, 8))
        else $error("serial out not eight edges behind serial in");

    a_status_load: assert property (@(posedge sclk_in) disable iff (!arst_n_in) // RULE16
        (mif.detect_mode && !mif.oe_lvl && low_cnt_q >= lsd_pkg::LOW_CNT_LOAD)
        |=> shreg_q == ($past(sink_q) & $past(level_ok)))
        else $error("status word not loaded on third low");

    a_no_early_load: assert property (@(posedge sclk_in) disable iff (!arst_n_in) // RULE15
        (mif.oe_lvl ##1 !mif.oe_lvl) |-> !load_status)
        else $error("status loaded before the second low");

    a_revert_serial: assert property (@(posedge sclk_in) disable iff (!arst_n_in) // RULE17
        (mif.detect_mode && mif.oe_lvl) |=> (shreg_q[0] == $past(serial_in_in)) && (sink_q == '0))
        else $error("enable high did not return to serial input");

    a_latch_copy: assert property (@(posedge sclk_in) disable iff (!arst_n_in) // RULE8
        (mif.le_lvl && !mif.latch_block) |=> latch_q == $past(shreg_q))
        else $error("latch did not copy shift register");

    a_latch_hold: assert property (@(posedge sclk_in) disable iff (!arst_n_in) // RULE21
        (!mif.le_lvl || mif.latch_block) |=> $stable(latch_q))
        else $error("latch changed while closed");

    a_sink_gate: assert property (@(posedge sclk_in) disable iff (!arst_n_in) // RULE9
        !mif.oe_lvl |=> channel_sink_out == latch_q)
        else $error("enabled sinks do not follow latch");

    a_settle_time: assert property (@(posedge clk_in) disable iff (!arst_n_in) // RULE18
        $rose(status_settled_out) |-> $past(settle_cnt_q) == lsd_pkg::SETTLE_LAST)
        else $error("settle flag raised early");

    a_settle_clear: assert property (@(posedge clk_in) disable iff (!arst_n_in) // RULE18
        oe_clk |=> !status_settled_out)
        else $error("settle flag kept while enable high");

    a_status_valid: assert property (@(posedge clk_in) disable iff (!arst_n_in) // RULE18
        status_settled_out |-> !$past(oe_clk))
        else $error("settle flag without enable low");

    // ********************************************************************
    // Checks on gating and detection
    // ********************************************************************
    // Three low samples in a row on the enable pin
    sequence s_three_lows;
        (!mif.oe_lvl) [*3];
    endsequence

    a_sink_off: assert property (@(posedge sclk_in) disable iff (!arst_n_in) // RULE20
        mif.oe_lvl |=> channel_sink_out == '0)
        else $error("sinks on while enable high");

    // Sinks never light a channel that the latch holds off
    a_sink_subset: assert property (@(posedge sclk_in) disable iff (!arst_n_in) // RULE9
        (channel_sink_out & ~latch_q) == '0)
        else $error("sink on without latch bit");

    a_switch_shift: assert property (@(posedge sclk_in) disable iff (!arst_n_in) // RULE6
        mif.latch_block |=> shreg_q == {$past(shreg_q[lsd_pkg::CH_NUM-2:0]), $past(serial_in_in)})
        else $error("shift stalled during mode switch");

    a_no_load_normal: assert property (@(posedge sclk_in) disable iff (!arst_n_in) // RULE7
        !mif.detect_mode |-> !load_status)
        else $error("status loaded in normal mode");

    a_third_low: assert property (@(posedge sclk_in) disable iff (!arst_n_in) // RULE16
        s_three_lows ##0 mif.detect_mode |-> load_status)
        else $error("third low did not load status");

    a_low_saturate: assert property (@(posedge sclk_in) disable iff (!arst_n_in) // RULE16
        (low_cnt_q == lsd_pkg::LOW_CNT_MAX) && !mif.oe_lvl |=> low_cnt_q == lsd_pkg::LOW_CNT_MAX)
        else $error("low count left saturation");

    a_count_clear: assert property (@(posedge sclk_in) disable iff (!arst_n_in) // RULE17
        mif.oe_lvl |=> low_cnt_q == lsd_pkg::LOW_CNT_RST)
        else $error("low count kept after enable high");

    // Off or under-threshold channels always read zero
    a_off_zero: assert property (@(posedge sclk_in) disable iff (!arst_n_in) // RULE11
        load_status |=> (shreg_q & ~$past(sink_q)) == '0)
        else $error("off channel reported one");

    a_short_code: assert property (@(posedge sclk_in) disable iff (!arst_n_in) // RULE13
        load_status |=> (shreg_q & ~$past(level_ok)) == '0)
        else $error("under-threshold channel reported one");

    a_healthy_status: assert property (@(posedge sclk_in) disable iff (!arst_n_in) // RULE14
        load_status && ((sink_q & ~level_ok) == '0)
        |=> shreg_q == $past(sink_q))
        else $error("healthy status differs from latch");

endmodule
`default_nettype wire

// ==== sim/lsd_ctrl_model.sv ====
// Display controller model that drives the serial link pins
`timescale 1ns/1ps
`default_nettype none
module lsd_ctrl_model #(
    parameter real HALF_NS = 7.5
) (
    output logic sclk_out,
    output logic serial_in_out,
    output logic latch_mode_select_out,
    output logic output_enable_switch_detect_out
);
    // ************************************************************
    // Idle levels
    // ************************************************************
    // Clock parked low between frames, sinks disabled
    initial begin
        sclk_out = 1'b0;
        serial_in_out = 1'b0;
        latch_mode_select_out = 1'b0;
        output_enable_switch_detect_out = 1'b1;
    end

    // ************************************************************
    // One link clock period
    // ************************************************************
    // Levels move at the falling edge, so each one is held across the sampling edge
    // A nonzero idle_ns parks the clock first, as a slow controller would
    task automatic clk_edge(input logic d, input logic l, input logic o, input int idle_ns);
        #(idle_ns);
        serial_in_out = d;
        latch_mode_select_out = l;
        output_enable_switch_detect_out = o;
        #(HALF_NS) sclk_out = 1'b1;
        #(HALF_NS) sclk_out = 1'b0;
    endtask
endmodule
`default_nettype wire

// ==== sim/tb_top.sv ====
// Self-checking bench for the LED sink driver control
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk_in = 1'b0;
    logic arst_n_in = 1'b0;
    logic sclk, serial_in, le, oe;
    lsd_pkg::lsd_word_t current_ok = 8'h00;
    logic serial_out, det, cap, settled;
    lsd_pkg::lsd_word_t sink;
    lsd_pkg::lsd_word_t exp_sr = 8'h00;
    lsd_pkg::lsd_word_t lat = 8'h00;
    int failures = 0;
    int num_checks = 0;
    int cyc = 0;

    // ************************************************************
    // Clock, instances, watchdog
    // ************************************************************
    // System clock, 40 ns period
    always #20 clk_in = ~clk_in;

    lsd_ctrl_model lsd_ctrl_model_inst (
        .sclk_out(sclk),
        .serial_in_out(serial_in),
        .latch_mode_select_out(le),
        .output_enable_switch_detect_out(oe)
    );

    lsd_top lsd_top_inst (
        .clk_in(clk_in),
        .arst_n_in(arst_n_in),
        .sclk_in(sclk),
        .serial_in_in(serial_in),
        .latch_mode_select_in(le),
        .output_enable_switch_detect_in(oe),
        .current_ok_in(current_ok),
        .serial_out_out(serial_out),
        .channel_sink_out(sink),
        .detect_mode_out(det),
        .status_capture_out(cap),
        .status_settled_out(settled)
    );

    // Whole run needs about two hundred cycles; a hang stops here
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 3000) begin
            failures++;
            close_out();
        end
    end

    // ************************************************************
    // Shared tasks
    // ************************************************************
    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string what, input lsd_pkg::lsd_word_t exp, input lsd_pkg::lsd_word_t seen);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask

    // One link edge; the bench tracks the shift register and checks the cascade bit
    task automatic stp(input logic d, input logic l, input logic o, input logic ld, input lsd_pkg::lsd_word_t w);
        lsd_ctrl_model_inst.clk_edge(d, l, o, 0);
        exp_sr = ld ? w : {exp_sr[6:0], d};
        chk("serial_out", lsd_pkg::lsd_word_t'(exp_sr[7]), lsd_pkg::lsd_word_t'(serial_out));
    endtask

    // Most significant bit first, sinks kept disabled
    task automatic shift_byte(input lsd_pkg::lsd_word_t b);
        for (int i = 7; i >= 0; i--) begin
            stp(b[i], 1'b0, 1'b1, 1'b0, 8'h00);
        end
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_reset();
        chk("mode_after_reset", 8'h00, lsd_pkg::lsd_word_t'(det));
        chk("sink_after_reset", 8'h00, sink);
    endtask

    // Latch, enable gating and hold; the latch takes the word standing before the shift
    task automatic t_latch();
        lsd_pkg::lsd_word_t pre;
        pre = exp_sr;
        stp(1'b1, 1'b1, 1'b1, 1'b0, 8'h00);
        chk("sink_disabled", 8'h00, sink);
        stp(1'b0, 1'b0, 1'b0, 1'b0, 8'h00);
        chk("sink_latched", pre, sink);
        lat = pre;
        stp(1'b1, 1'b0, 1'b0, 1'b0, 8'h00);
        stp(1'b0, 1'b0, 1'b0, 1'b0, 8'h00);
        chk("sink_held", lat, sink);
        stp(1'b1, 1'b0, 1'b1, 1'b0, 8'h00);
        chk("sink_off", 8'h00, sink);
    endtask

    // Short 101 pulse, mode chosen by the latch line on the fourth edge
    task automatic t_switch(input logic to_det);
        stp(1'b1, 1'b0, 1'b1, 1'b0, 8'h00);
        stp(1'b0, 1'b0, 1'b0, 1'b0, 8'h00);
        chk("sink_pulse_low", lat, sink);
        stp(1'b1, 1'b1, 1'b1, 1'b0, 8'h00);
        chk("sink_pulse_high", 8'h00, sink);
        stp(1'b0, to_det, 1'b1, 1'b0, 8'h00);
        stp(1'b1, 1'b1, 1'b1, 1'b0, 8'h00);
        stp(1'b0, 1'b0, 1'b1, 1'b0, 8'h00);
        wait_clk(8);
        chk("mode", lsd_pkg::lsd_word_t'(to_det), lsd_pkg::lsd_word_t'(det));
        stp(1'b0, 1'b0, 1'b0, 1'b0, 8'h00);
        stp(1'b1, 1'b0, 1'b0, 1'b0, 8'h00);
        chk("latch_kept", lat, sink);
        stp(1'b0, 1'b0, 1'b1, 1'b0, 8'h00);
    endtask

    // Detection window with sinks kept enabled
    task automatic t_detect(input lsd_pkg::lsd_word_t c);
        lsd_pkg::lsd_word_t st;
        logic seen;
        st = lat & c;
        seen = 1'b0;
        current_ok = c;
        repeat (4) stp(1'b1, 1'b0, 1'b1, 1'b0, 8'h00);
        stp(1'b0, 1'b0, 1'b0, 1'b0, 8'h00);
        chk("sink_detect", lat, sink);
        stp(1'b1, 1'b0, 1'b0, 1'b0, 8'h00);
        stp(1'b0, 1'b0, 1'b0, 1'b1, st);
        for (int i = 0; i < 12; i++) begin
            wait_clk(1);
            if (cap === 1'b1) seen = 1'b1;
        end
        chk("status_capture", 8'h01, lsd_pkg::lsd_word_t'(seen));
        chk("status_early", 8'h00, lsd_pkg::lsd_word_t'(settled));
        stp(1'b1, 1'b0, 1'b0, 1'b1, st);
        wait_clk(55);
        chk("status_settled", 8'h01, lsd_pkg::lsd_word_t'(settled));
        stp(1'b0, 1'b0, 1'b1, 1'b0, 8'h00);
        chk("sink_after_detect", 8'h00, sink);
        shift_byte(8'h00);
    endtask

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        repeat (2) lsd_ctrl_model_inst.clk_edge(1'b0, 1'b0, 1'b1, 3);
        repeat (6) @(posedge clk_in);
        #1 arst_n_in = 1'b1;
        t_reset();
        shift_byte(8'hC5);
        shift_byte(8'h96);
        t_latch();
        shift_byte(8'h3A);
        t_switch(1'b1);
        t_detect(8'hFF);
        t_detect(8'h5A);
        t_switch(1'b0);
        repeat (3) stp(1'b1, 1'b0, 1'b0, 1'b0, 8'h00);
        stp(1'b0, 1'b0, 1'b1, 1'b0, 8'h00);
        close_out();
    end
endmodule
`default_nettype wire
